// file: core/csf_serial_port.sv
// csf_serial_port: framed codec serial port with APB registers,
// bit clock generator, slot sequencer and 4-word rx/tx buffers.
// assumes an APB master on sys_clk; pins arrive asynchronous.
//
// Notes on behaviour
// - buffer depth field plus one words pass between buffer events
// - frame holds frame-length field plus one words
// - word length in bits is word-size field plus one
// - twelve-bit bit clock divider sets internal bit clock rate
// - status shows index of the currently active slot
// - receive overflow flag set when a full buffer is overwritten
// - receive full flag shows fresh data in the receive buffer
// - transmit underflow flag set when an empty buffer is sent
// - transmit empty flag shows the transmit buffer drained
// - serial input captured only in enabled receive slots
// - transmit buffer sent in enabled transmit slots
// - disabled transmit slots float or drive low
// - unimplemented register bits read as zero
// - idle drive mode one floats, zero drives low
// - underflow sends last written word or zeros per fill mode
// - two-bit field picks frame sync format
// - port runs only while the enable bit is set
`timescale 1ns/100ps
module csf_serial_port
  import csf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_bit_clock_pin_in,
  output logic             serial_bit_clock_pin_out,
  output logic             serial_bit_clock_pin_oe,
  output logic             frame_sync_out,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  output logic             buffer_event
);

  csf_cfg_t  cfg_q;
  csf_stat_t st_q;
  logic [15:0] last_tx_q;
  logic [31:0] rd_val;
  logic        acc, wr_acc, rd_acc, mapped;
  logic [1:0]  baddr;

  // apb: one wait state so buffer read data come from a register
  assign acc    = psel & penable & pready;
  assign wr_acc = acc & pwrite & mapped; // refused addresses never write
  assign rd_acc = acc & ~pwrite;
  assign baddr  = paddr[3:2];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // software configuration registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_q     <= '0;
      last_tx_q <= CSF_RST_REG16;
    end else if (wr_acc) begin
      case (paddr)
        CSF_OFF_CTRL: begin
          cfg_q.enable               <= pwdata[CSF_CTRL_EN];
          cfg_q.ext_clock            <= pwdata[CSF_CTRL_EXTCK];
          cfg_q.underflow_fill_mode  <= pwdata[CSF_CTRL_UFM];
          cfg_q.idle_slot_drive_mode <= pwdata[CSF_CTRL_IDLE];
          cfg_q.frame_sync_format    <= csf_fmt_t'(pwdata[CSF_CTRL_FMT +: 2]);
        end
        CSF_OFF_FRAME: begin
          cfg_q.buffer_depth_sel <= pwdata[CSF_FRM_DEPTH +: 2];
          cfg_q.frame_length_sel <= pwdata[CSF_FRM_LEN +: 4];
          cfg_q.word_length_sel  <= pwdata[CSF_FRM_WS +: 4];
        end
        CSF_OFF_BCLK:   cfg_q.bit_clock_divider   <= pwdata[11:0];
        CSF_OFF_RXSLOT: cfg_q.rx_slot_enable_mask <= pwdata[15:0];
        CSF_OFF_TXSLOT: cfg_q.tx_slot_enable_mask <= pwdata[15:0];
        default: begin
          if (paddr[7:4] == CSF_OFF_TXBUF[7:4]) begin
            last_tx_q <= pwdata[15:0];
          end
        end
      endcase
    end
  end

  // pin synchronisers: stage one feeds stage two only
  logic [1:0] sck_s, sdi_s;
  logic       sck_d;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sck_s <= 2'b00;
      sdi_s <= 2'b00;
      sck_d <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], serial_bit_clock_pin_in};
      sdi_s <= {sdi_s[0], serial_data_in};
      sck_d <= sck_s[1];
    end
  end

  // internal bit clock: half period is divider plus one sys_clk cycles
  logic [11:0] div_q;
  logic        bclk_q;
  logic        run;
  assign run = cfg_q.enable;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run || cfg_q.ext_clock) begin
      div_q  <= CSF_RST_BCG;
      bclk_q <= 1'b0;
    end else if (div_q == cfg_q.bit_clock_divider) begin
      div_q  <= CSF_RST_BCG;
      bclk_q <= ~bclk_q;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  // edge ticks; data change on falling, sampled on rising
  logic int_tick, rise, fall;
  assign int_tick = run & ~cfg_q.ext_clock & (div_q == cfg_q.bit_clock_divider);
  assign rise = cfg_q.ext_clock ? (run & sck_s[1] & ~sck_d) : (int_tick & ~bclk_q);
  assign fall = cfg_q.ext_clock ? (run & ~sck_s[1] & sck_d) : (int_tick & bclk_q);

  // sequencer state
  logic [3:0]  bit_q;
  logic [3:0]  slot_q;
  logic [1:0]  idx_q;
  logic        started_q;
  logic [15:0] tx_sh_q, rx_sh_q;
  logic [15:0] tx_rdata, rx_rdata, rx_word, rx_next;
  logic        slot_rx, slot_tx, slot_used, word_end, buf_wrap;
  logic        rx_we;

  assign slot_rx   = cfg_q.rx_slot_enable_mask[slot_q];
  assign slot_tx   = cfg_q.tx_slot_enable_mask[slot_q];
  assign slot_used = slot_rx | slot_tx;
  // word length relies on software keeping the size at four bits or more
  assign word_end  = rise & started_q & (bit_q == cfg_q.word_length_sel);
  assign buf_wrap  = word_end & slot_used & (idx_q == cfg_q.buffer_depth_sel);
  assign rx_next   = {rx_sh_q[14:0], sdi_s[1]};
  // received words are stored left justified, low bits zero
  assign rx_word   = rx_next << (4'hf - cfg_q.word_length_sel);
  assign rx_we     = word_end & slot_rx;

  // bit counter, slot index and buffer pointer
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run) begin
      bit_q     <= 4'h0;
      slot_q    <= 4'h0;
      idx_q     <= 2'b00;
      started_q <= 1'b0;
    end else begin
      if (fall) begin
        started_q <= 1'b1;
      end
      if (word_end) begin
        bit_q <= 4'h0;
        if (slot_q == cfg_q.frame_length_sel) begin
          slot_q <= 4'h0;
        end else begin
          slot_q <= slot_q + 4'h1;
        end
        if (slot_used) begin
          idx_q <= buf_wrap ? 2'b00 : idx_q + 2'b01;
        end
      end else if (rise && started_q) begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end

  // transmit word chosen at the first falling edge of a word
  logic [15:0] tx_load;
  logic        tx_under;
  assign tx_under = st_q.tx_empty_flag & slot_tx;
  always_comb begin
    if (!tx_under) begin
      tx_load = tx_rdata;
    end else if (cfg_q.underflow_fill_mode) begin
      tx_load = last_tx_q;
    end else begin
      tx_load = 16'h0000;
    end
  end

  // shift registers, msb first
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run) begin
      tx_sh_q <= 16'h0000;
      rx_sh_q <= 16'h0000;
    end else begin
      if (fall) begin
        tx_sh_q <= (bit_q == 4'h0) ? tx_load : {tx_sh_q[14:0], 1'b0};
      end
      if (rise && started_q) begin
        rx_sh_q <= word_end ? 16'h0000 : rx_next;
      end
    end
  end

  // serial output pin; idle slots float or drive low
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run) begin
      serial_data_out    <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else if (fall) begin
      if (slot_tx) begin
        serial_data_out    <= (bit_q == 4'h0) ? tx_load[15] : tx_sh_q[14];
        serial_data_out_oe <= 1'b1;
      end else begin
        serial_data_out    <= 1'b0;
        serial_data_out_oe <= ~cfg_q.idle_slot_drive_mode;
      end
    end
  end

  // frame sync, shape set by the format field
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run) begin
      frame_sync_out <= 1'b0;
    end else if (fall) begin
      case (cfg_q.frame_sync_format)
        CSF_FMT_MULTI: frame_sync_out <= (slot_q == 4'h0) && (bit_q == 4'h0);
        CSF_FMT_I2S:   frame_sync_out <= slot_q[0];
        CSF_FMT_AC16,
        CSF_FMT_AC20:  frame_sync_out <= (slot_q == 4'h0);
        default:       frame_sync_out <= 1'b0;
      endcase
    end
  end

  // bit clock pin: driven only when generated internally
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_bit_clock_pin_out <= 1'b0;
      serial_bit_clock_pin_oe  <= 1'b0;
    end else begin
      serial_bit_clock_pin_out <= bclk_q;
      serial_bit_clock_pin_oe  <= run & ~cfg_q.ext_clock;
    end
  end

  // status flags; a hardware set wins over a software clear
  logic st_rd, rx_rd, tx_wr;
  assign st_rd = rd_acc & (paddr == CSF_OFF_STATUS);
  assign rx_rd = rd_acc & (paddr[7:4] == CSF_OFF_RXBUF[7:4]);
  assign tx_wr = wr_acc & (paddr[7:4] == CSF_OFF_TXBUF[7:4]);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q.rx_overrun_flag   <= CSF_RST_FLAG;
      st_q.rx_full_flag      <= CSF_RST_FLAG;
      st_q.tx_underflow_flag <= CSF_RST_FLAG;
      st_q.tx_empty_flag     <= CSF_RST_FLAG;
      buffer_event           <= 1'b0;
      st_q.slot              <= 4'h0;
    end else begin
      buffer_event <= buf_wrap;
      st_q.slot    <= slot_q; // status copy lags the sequencer by one cycle
      if (st_rd) begin
        st_q.rx_overrun_flag   <= 1'b0;
        st_q.tx_underflow_flag <= 1'b0;
      end
      if (rx_rd) begin
        st_q.rx_full_flag <= 1'b0;
      end
      if (tx_wr) begin
        st_q.tx_empty_flag <= 1'b0;
      end
      if (rx_we && st_q.rx_full_flag) begin
        st_q.rx_overrun_flag <= 1'b1;
      end
      if (fall && bit_q == 4'h0 && tx_under) begin
        st_q.tx_underflow_flag <= 1'b1;
      end
      if (buf_wrap && cfg_q.rx_slot_enable_mask != 16'h0000) begin
        st_q.rx_full_flag <= 1'b1;
      end
      if (buf_wrap && cfg_q.tx_slot_enable_mask != 16'h0000) begin
        st_q.tx_empty_flag <= 1'b1;
      end
    end
  end

  // buffers: rx written by the sequencer, tx by software
  csf_word_mem #(.WIDTH(CSF_WORD_W), .DEPTH(CSF_BUF_WORDS)) u_rx_mem (
    .sys_clk (sys_clk),
    .we      (rx_we),
    .waddr   (idx_q),
    .wdata   (rx_word),
    .raddr   (baddr),
    .rdata   (rx_rdata)
  );

  csf_word_mem #(.WIDTH(CSF_WORD_W), .DEPTH(CSF_BUF_WORDS)) u_tx_mem (
    .sys_clk (sys_clk),
    .we      (tx_wr),
    .waddr   (baddr),
    .wdata   (pwdata[15:0]),
    .raddr   (idx_q),
    .rdata   (tx_rdata)
  );

  // read mux; every unimplemented bit reads zero
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      CSF_OFF_CTRL: begin
        rd_val[CSF_CTRL_EN]        = cfg_q.enable;
        rd_val[CSF_CTRL_EXTCK]     = cfg_q.ext_clock;
        rd_val[CSF_CTRL_UFM]       = cfg_q.underflow_fill_mode;
        rd_val[CSF_CTRL_IDLE]      = cfg_q.idle_slot_drive_mode;
        rd_val[CSF_CTRL_FMT +: 2]  = cfg_q.frame_sync_format;
      end
      CSF_OFF_FRAME: begin
        rd_val[CSF_FRM_DEPTH +: 2] = cfg_q.buffer_depth_sel;
        rd_val[CSF_FRM_LEN +: 4]   = cfg_q.frame_length_sel;
        rd_val[CSF_FRM_WS +: 4]    = cfg_q.word_length_sel;
      end
      CSF_OFF_BCLK:   rd_val[11:0] = cfg_q.bit_clock_divider;
      CSF_OFF_STATUS: begin
        rd_val[CSF_ST_SLOT +: 4]   = st_q.slot;
        rd_val[CSF_ST_ROV]         = st_q.rx_overrun_flag;
        rd_val[CSF_ST_RX_FULL_FLAG]        = st_q.rx_full_flag;
        rd_val[CSF_ST_TX_UNDERFLOW_FLAG]        = st_q.tx_underflow_flag;
        rd_val[CSF_ST_TX_EMPTY_FLAG]       = st_q.tx_empty_flag;
      end
      CSF_OFF_RXSLOT: rd_val[15:0] = cfg_q.rx_slot_enable_mask;
      CSF_OFF_TXSLOT: rd_val[15:0] = cfg_q.tx_slot_enable_mask;
      default: begin
        if (paddr[7:4] == CSF_OFF_RXBUF[7:4]) begin
          rd_val[15:0] = rx_rdata;
        end else if (paddr[7:4] != CSF_OFF_TXBUF[7:4]) begin
          mapped = 1'b0;
        end
      end
    endcase
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // read data and error registered in the first access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : rd_val;
      pslverr <= ~mapped;
    end else begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

endmodule // csf_serial_port

// file: core/csf_word_mem.sv
// csf_word_mem: small word buffer, one write port, registered read.
// assumes both ports run on sys_clk; read data lag the address by one edge.
`timescale 1ns/100ps
module csf_word_mem
  import csf_pkg::*;
#(
  parameter int WIDTH = CSF_WORD_W,
  parameter int DEPTH = CSF_BUF_WORDS
) (
  input  wire logic                     sys_clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // storage has no reset; the write port fills it before use
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge sys_clk) begin
    rdata <= mem[raddr];
  end

endmodule // csf_word_mem

// file: shared/csf_pkg.sv
// csf_pkg: register map, field positions, reset values and carriers
// for the framed codec serial port; assumes a 32-bit APB register bus.
package csf_pkg;

  // register byte offsets
  localparam logic [7:0] CSF_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CSF_OFF_FRAME  = 8'h04;
  localparam logic [7:0] CSF_OFF_BCLK   = 8'h08;
  localparam logic [7:0] CSF_OFF_STATUS = 8'h0c;
  localparam logic [7:0] CSF_OFF_RXSLOT = 8'h10;
  localparam logic [7:0] CSF_OFF_TXSLOT = 8'h14;
  localparam logic [7:0] CSF_OFF_TXBUF  = 8'h20;
  localparam logic [7:0] CSF_OFF_RXBUF  = 8'h30;

  // control register fields
  localparam int CSF_CTRL_EN    = 15;
  localparam int CSF_CTRL_EXTCK = 10;
  localparam int CSF_CTRL_UFM   = 7;
  localparam int CSF_CTRL_IDLE  = 6;
  localparam int CSF_CTRL_FMT   = 0;

  // frame and word configuration fields
  localparam int CSF_FRM_DEPTH = 10;
  localparam int CSF_FRM_LEN   = 5;
  localparam int CSF_FRM_WS    = 0;

  // status fields
  localparam int CSF_ST_SLOT  = 8;
  localparam int CSF_ST_ROV   = 3;
  localparam int CSF_ST_RX_FULL_FLAG  = 2;
  localparam int CSF_ST_TX_UNDERFLOW_FLAG  = 1;
  localparam int CSF_ST_TX_EMPTY_FLAG = 0;

  // values after reset
  localparam logic [15:0] CSF_RST_REG16 = 16'h0000;
  localparam logic [11:0] CSF_RST_BCG   = 12'h000;
  localparam logic        CSF_RST_FLAG  = 1'b0;

  // buffer geometry
  localparam int CSF_BUF_WORDS = 4;
  localparam int CSF_WORD_W    = 16;

  typedef enum logic [1:0] {
    CSF_FMT_MULTI,
    CSF_FMT_I2S,
    CSF_FMT_AC16,
    CSF_FMT_AC20
  } csf_fmt_t;

  // software configuration travelling as one bundle
  typedef struct packed {
    logic        enable;
    logic        ext_clock;
    logic        underflow_fill_mode;
    logic        idle_slot_drive_mode;
    csf_fmt_t    frame_sync_format;
    logic [1:0]  buffer_depth_sel;
    logic [3:0]  frame_length_sel;
    logic [3:0]  word_length_sel;
    logic [11:0] bit_clock_divider;
    logic [15:0] rx_slot_enable_mask;
    logic [15:0] tx_slot_enable_mask;
  } csf_cfg_t;

  // status flags seen by software
  typedef struct packed {
    logic [3:0] slot;
    logic       rx_overrun_flag;
    logic       rx_full_flag;
    logic       tx_underflow_flag;
    logic       tx_empty_flag;
  } csf_stat_t;

endpackage

// file: tb/csf_asserts.sv
// csf_asserts: port-level checks on the codec serial port
// assumes one sys_clk domain; bound to every instance below
`timescale 1ns/100ps
module csf_asserts (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_bit_clock_pin_in,
  input wire logic        serial_bit_clock_pin_out,
  input wire logic        serial_bit_clock_pin_oe,
  input wire logic        frame_sync_out,
  input wire logic        serial_data_in,
  input wire logic        serial_data_out,
  input wire logic        serial_data_out_oe,
  input wire logic        buffer_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // apb steps: setup, then a first access cycle that waits
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && !pready;
  endsequence
  // outputs move on the fall tick, the pin follows one cycle later
  sequence clk_last_high_s;
    serial_bit_clock_pin_out ##1 !serial_bit_clock_pin_out;
  endsequence
  apb_one_wait_a: assert property (setup_s ##1 access_s |=> pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held over two cycles");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_data_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside a transfer");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  event_pulse_a: assert property (buffer_event |=> !buffer_event)
    else $error("buffer event longer than one cycle");
  sdo_hold_a: assert property ($changed(serial_data_out) && serial_bit_clock_pin_oe |-> clk_last_high_s)
    else $error("serial data moved away from a bit clock fall");
  fsync_edge_a: assert property ($changed(frame_sync_out) && serial_bit_clock_pin_oe |-> clk_last_high_s)
    else $error("frame sync moved away from a bit clock fall");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !pready && !buffer_event && !serial_data_out_oe)
    else $error("outputs active right after reset");
endmodule // csf_asserts

bind csf_serial_port csf_asserts i_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_bit_clock_pin_in(serial_bit_clock_pin_in), .serial_bit_clock_pin_out(serial_bit_clock_pin_out),
  .serial_bit_clock_pin_oe(serial_bit_clock_pin_oe), .frame_sync_out(frame_sync_out),
  .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe), .buffer_event(buffer_event));

// file: tb/csf_codec_model.sv
// csf_codec_model: far-side codec for the serial port bench
// assumes the port drives on falling and the codec samples on rising bit clock
`timescale 1ns/100ps
module csf_codec_model (
  input  wire logic        run_ext,
  input  wire logic        din_level,
  input  wire logic        serial_bit_clock_pin_out,
  input  wire logic        serial_data_out,
  input  wire logic        serial_data_out_oe,
  output logic             serial_bit_clock_pin_in,
  output logic             serial_data_in,
  output logic [15:0]      tx_seen
);
  // 64 ns bit clock, still between runs, phase off the system clock
  initial begin
    serial_bit_clock_pin_in = 1'b0;
    #3;
    forever #32 serial_bit_clock_pin_in <= run_ext ? ~serial_bit_clock_pin_in : 1'b0;
  end
  assign serial_data_in = din_level;
  // shift in port data only while it drives the line
  initial tx_seen = 16'h0;
  always @(posedge serial_bit_clock_pin_out) begin
    if (serial_data_out_oe)
      tx_seen <= {tx_seen[14:0], serial_data_out};
  end
endmodule // csf_codec_model

// file: tb/tb_top.sv
// tb_top: register and serial scenarios for csf_serial_port
// assumes the checker binds itself and the codec model sits on the pins
`timescale 1ns/100ps
module tb_top;
  import csf_pkg::*;
  logic        sys_clk, sys_rst, psel, penable, pwrite, run_ext, din_level;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, sck_in, sck_out, sck_oe, fsync, sdi, sdo, sdo_oe, buffer_event, e;
  logic [15:0] tx_seen;
  logic [3:0]  max_slot;
  int          err_total, n_checks, t, oe_n, out_n, ev_n, fs_n;

  csf_serial_port i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_bit_clock_pin_in(sck_in), .serial_bit_clock_pin_out(sck_out),
    .serial_bit_clock_pin_oe(sck_oe), .frame_sync_out(fsync), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .buffer_event(buffer_event));
  csf_codec_model i_codec (.run_ext(run_ext), .din_level(din_level), .serial_bit_clock_pin_out(sck_out),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .serial_bit_clock_pin_in(sck_in),
    .serial_data_in(sdi), .tx_seen(tx_seen));

  // 125 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; held until pready is sampled, idle cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // cycles from now to the next buffer event, bounded
  task automatic wait_evt();
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (buffer_event !== 1'b1 && t < 5000);
    if (t >= 5000) begin
      err_total++;
      print_verdict();
    end
  endtask

  // count drive, high data, frame sync and events over a window
  task automatic watch(input int n);
    oe_n = 0;
    out_n = 0;
    ev_n = 0;
    fs_n = 0;
    repeat (n) begin
      @(posedge sys_clk);
      oe_n += (sdo_oe === 1'b1);
      out_n += (sdo === 1'b1 && sdo_oe === 1'b1);
      ev_n += (buffer_event === 1'b1);
      fs_n += (fsync === 1'b1);
    end
  endtask

  initial begin
    {sys_rst, psel, penable, pwrite, run_ext, din_level} = 6'b100001;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // reset values
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
    $display("test reset_values done");
    // access kinds, masks and refusals
    apb(1'b1, CSF_OFF_FRAME, 32'hffff);
    rd(CSF_OFF_FRAME, 32'h0def);
    apb(1'b1, CSF_OFF_BCLK, 32'hffff);
    rd(CSF_OFF_BCLK, 32'h0fff);
    apb(1'b1, CSF_OFF_RXSLOT, 32'hffff);
    rd(CSF_OFF_RXSLOT, 32'hffff);
    apb(1'b1, CSF_OFF_TXSLOT, 32'hffff);
    rd(CSF_OFF_TXSLOT, 32'hffff);
    apb(1'b1, CSF_OFF_CTRL, 32'h7fff);
    rd(CSF_OFF_CTRL, 32'h04c3);
    apb(1'b1, CSF_OFF_STATUS, 32'hffff);
    rd(CSF_OFF_STATUS, 32'h0);
    apb(1'b1, 8'h1c, 32'h1);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, CSF_OFF_CTRL, 32'(f));
      rd(CSF_OFF_CTRL, 32'(f));
    end
    $display("test registers done");
    // 16-bit words, one slot, last word repeated on underflow
    apb(1'b1, CSF_OFF_CTRL, 32'h0);
    apb(1'b1, CSF_OFF_FRAME, 32'h000f);
    apb(1'b1, CSF_OFF_BCLK, 32'h2);
    apb(1'b1, CSF_OFF_RXSLOT, 32'h1);
    apb(1'b1, CSF_OFF_TXSLOT, 32'h1);
    apb(1'b1, CSF_OFF_TXBUF, 32'hc35a);
    apb(1'b1, CSF_OFF_CTRL, 32'h8080);
    wait_evt();
    wait_evt();
    chk(t, 32'd96);
    // two words plus a few cycles, so the model holds one whole word
    repeat (196) @(posedge sys_clk);
    chk(tx_seen, 16'hc35a);
    rd(CSF_OFF_STATUS, 32'h000f);
    rd(CSF_OFF_RXBUF, 32'hffff);
    // four words between buffer events
    apb(1'b1, CSF_OFF_CTRL, 32'h0);
    apb(1'b1, CSF_OFF_FRAME, 32'h0c0f);
    apb(1'b1, CSF_OFF_CTRL, 32'h8080);
    wait_evt();
    wait_evt();
    chk(t, 32'd384);
    $display("test word_16 done");
    // 4-bit words, zeros on underflow
    apb(1'b1, CSF_OFF_CTRL, 32'h0);
    apb(1'b1, CSF_OFF_FRAME, 32'h0003);
    apb(1'b1, CSF_OFF_TXBUF, 32'hc35a);
    apb(1'b1, CSF_OFF_CTRL, 32'h8000);
    wait_evt();
    wait_evt();
    chk(t, 32'd24);
    rd(CSF_OFF_RXBUF, 32'hf000);
    repeat (200) @(posedge sys_clk);
    chk(tx_seen, 16'h0);
    apb(1'b1, CSF_OFF_CTRL, 32'h0);
    watch(300);
    chk(oe_n + ev_n + fs_n, 32'h0);
    $display("test word_4 done");
    // disabled transmit slots: float, then drive low
    apb(1'b1, CSF_OFF_FRAME, 32'h000f);
    apb(1'b1, CSF_OFF_TXSLOT, 32'h0);
    apb(1'b1, CSF_OFF_CTRL, 32'h8040);
    watch(300);
    chk(oe_n, 32'h0);
    chk(32'(fs_n > 0), 32'h1);
    apb(1'b1, CSF_OFF_CTRL, 32'h8000);
    watch(300);
    chk(32'(oe_n > 0), 32'h1);
    chk(out_n, 32'h0);
    $display("test idle_slots done");
    // three-slot frame, slot index wraps after slot 2
    apb(1'b1, CSF_OFF_CTRL, 32'h0);
    apb(1'b1, CSF_OFF_FRAME, 32'h004f);
    apb(1'b1, CSF_OFF_CTRL, 32'h8000);
    max_slot = 4'h0;
    repeat (100) begin
      apb(1'b0, CSF_OFF_STATUS, 32'h0);
      if (r[11:8] > max_slot) max_slot = r[11:8];
    end
    chk(max_slot, 4'h2);
    $display("test slots done");
    // external 64 ns bit clock
    apb(1'b1, CSF_OFF_CTRL, 32'h0);
    apb(1'b1, CSF_OFF_FRAME, 32'h000f);
    run_ext <= 1'b1;
    apb(1'b1, CSF_OFF_CTRL, 32'h8400);
    wait_evt();
    wait_evt();
    chk(t, 32'd128);
    chk(sck_oe, 1'b0);
    run_ext <= 1'b0;
    $display("test ext_clock done");
    print_verdict();
  end
endmodule // tb_top
